// [src/emb_regs.svh]
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define EMB_CTRL_OFS 8'h00
`define EMB_PULLUP_OFS 8'h04
`define EMB_PMD_OFS 8'h08
`define EMB_STATUS_OFS 8'h0c

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define EMB_CTRL_RST 8'h30
`define EMB_CTRL_WMASK 8'hb3
`define EMB_CTRL_DIS_BIT 7
`define EMB_CTRL_WAIT_MSB 5
`define EMB_CTRL_WAIT_LSB 4
`define EMB_CTRL_MODE_MSB 1
`define EMB_CTRL_MODE_LSB 0
`define EMB_PULLUP_RST 8'h00
`define EMB_PMD_RST 8'h00
`define EMB_PMD_WMASK 8'hfd
`define EMB_PMD_OFF_BIT 0
`define EMB_CODE_BYTE_WRITE 2'h0
`define EMB_CODE_WORD_WRITE 2'h1
`define EMB_CODE_BYTE_SELECT 2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EMB_TCY_CLKS 8
`endif

// [src/emb_pkg.sv]
package emb_pkg;
  typedef enum logic [1:0] {OP_FETCH, OP_TREAD, OP_TWRITE} emb_op_e;
  typedef enum logic [1:0] {WMODE_BYTE_WRITE, WMODE_WORD_WRITE, WMODE_BYTE_SELECT} emb_wmode_e;
  typedef enum logic {ST_IDLE, ST_RUN} emb_state_e;
  typedef struct packed {
    emb_op_e op;
    logic [20:0] table_pointer;
    logic [7:0] table_latch_byte;
  } emb_req_s;
  typedef struct packed {
    logic [3:0] addr_hi;
    logic [15:0] ad;
    logic [1:0] ad_oe;
    logic ale;
    logic oe_n;
    logic write_high_strobe_n;
    logic write_low_strobe_n;
    logic ce_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
    logic byte_address_lsb;
  } emb_pins_s;
endpackage : emb_pkg

// [src/emb_axil_slave.sv]
`timescale 1ns/1ns
`default_nettype none
module emb_axil_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic reg_wr,
  output logic [ADDR_W-1:0] reg_waddr,
  output logic [7:0] reg_wdata,
  input wire logic reg_wok,
  output logic [ADDR_W-1:0] reg_raddr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rok
);
  logic [31:0] wdata;
  logic [3:0] wstrb;
  // awready low means an address is held; same for wready
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire both_held = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  // only lane 0 carries register bits; other lanes are ignored
  assign reg_wr = both_held & wstrb[0] & reg_wok;
  assign reg_wdata = wdata[7:0];
  assign reg_raddr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      reg_waddr <= '0;
      wdata <= '0;
      wstrb <= '0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        reg_waddr <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      if (both_held) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_wok ? 2'h0 : 2'h3;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, reg_rdata};
      s_axi_rresp <= reg_rok ? 2'h0 : 2'h3;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : emb_axil_slave
`default_nettype wire

// [src/emb_bus_ctrl.sv]
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "emb_regs.svh"
module emb_bus_ctrl #(
  parameter int TCY_CLKS = `EMB_TCY_CLKS,
  parameter bit PKG_64PIN = 1'b0,
  parameter logic [1:0] CODE_BYTE_WRITE = `EMB_CODE_BYTE_WRITE,
  parameter logic [1:0] CODE_WORD_WRITE = `EMB_CODE_WORD_WRITE,
  parameter logic [1:0] CODE_BYTE_SELECT = `EMB_CODE_BYTE_SELECT,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core requests
  input wire logic req_valid,
  input wire emb_pkg::emb_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // power mode and configuration
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic exec_external,
  input wire logic width_8bit,
  input wire logic wait_enable,
  // bus pins
  input wire logic [15:0] ad_in,
  output var emb_pkg::emb_pins_s pins,
  output logic pins_to_bus,
  // static controls
  output logic [7:0] pull_up_config,
  output logic [7:0] module_power_disable
);
  import emb_pkg::*;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  localparam int LW = 8;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction : merge

  // {mapped, index}
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`EMB_CTRL_OFS)) reg_index = 3'h4;
    else if (a == ADDR_W'(`EMB_PULLUP_OFS)) reg_index = 3'h5;
    else if (a == ADDR_W'(`EMB_PMD_OFS)) reg_index = 3'h6;
    else if (a == ADDR_W'(`EMB_STATUS_OFS)) reg_index = 3'h7;
    else reg_index = 3'h0;
  endfunction : reg_index

  // unknown code falls back to byte write
  function automatic emb_wmode_e decode_mode(input logic [1:0] code);
    if (code == CODE_WORD_WRITE) decode_mode = WMODE_WORD_WRITE;
    else if (code == CODE_BYTE_SELECT) decode_mode = WMODE_BYTE_SELECT;
    else decode_mode = WMODE_BYTE_WRITE;
  endfunction : decode_mode

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [7:0] ext_bus_control;
  logic reg_wr;
  logic [ADDR_W-1:0] reg_waddr;
  logic [ADDR_W-1:0] reg_raddr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  emb_state_e state;
  emb_state_e next_state;

  wire [2:0] widx = reg_index(reg_waddr);
  wire [2:0] ridx = reg_index(reg_raddr);
  wire low_power = sleep_mode | idle_mode;
  wire [7:0] status = {5'h0, pins_to_bus, low_power, state == ST_RUN};
  // control reads zero on the small package
  wire [7:0] ctrl_view = PKG_64PIN ? 8'h00 : ext_bus_control;
  assign reg_rdata = ridx == 3'h4 ? ctrl_view :
                     ridx == 3'h5 ? pull_up_config :
                     ridx == 3'h6 ? (module_power_disable & `EMB_PMD_WMASK) :
                     ridx == 3'h7 ? status : 8'h00;

  emb_axil_slave #(.ADDR_W(ADDR_W)) u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wok(widx[2]),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rok(ridx[2])
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_bus_control <= `EMB_CTRL_RST;
      pull_up_config <= `EMB_PULLUP_RST;
      module_power_disable <= `EMB_PMD_RST;
    end else if (reg_wr) begin
      if (widx == 3'h4 && !PKG_64PIN)
        ext_bus_control <= merge(ext_bus_control, reg_wdata, `EMB_CTRL_WMASK);
      if (widx == 3'h5)
        pull_up_config <= reg_wdata;
      if (widx == 3'h6)
        module_power_disable <= merge(module_power_disable, reg_wdata, `EMB_PMD_WMASK);
    end
  end

  // ------------------------------------------------------------
  // access sequencing
  // ------------------------------------------------------------
  emb_req_s cur;
  emb_pins_s next_pins;
  emb_pins_s run_pins;
  logic [LW-1:0] ph;
  logic [LW-1:0] cur_len;
  logic [7:0] hold_latch;
  logic [7:0] lo_byte;
  logic [15:0] ad_s1;
  logic [15:0] ad_s2;

  wire bus_off = module_power_disable[`EMB_PMD_OFF_BIT];
  wire accept = req_valid & req_ready & ~low_power & ~bus_off;
  emb_wmode_e mode;
  assign mode = decode_mode(ext_bus_control[`EMB_CTRL_MODE_MSB:`EMB_CTRL_MODE_LSB]);
  wire [1:0] wait_n = wait_enable ?
                      ext_bus_control[`EMB_CTRL_WAIT_MSB:`EMB_CTRL_WAIT_LSB] : 2'h0;
  // a wait state is one more whole instruction cycle after the first
  wire [LW-1:0] len_w = LW'(TCY_CLKS * (1 + int'(wait_n)));
  wire [LW-1:0] half = cur_len >> 1;
  wire last_ph = ph == cur_len - 1'b1;
  wire second = ph >= half;
  wire is_wr = cur.op == OP_TWRITE;
  wire ptr0 = cur.table_pointer[0];
  wire [7:0] d = cur.table_latch_byte;
  wire running = state == ST_RUN && !low_power;
  // samples in ad_s2 lag the pins by two cycles and ph by three, so capture points sit late
  wire grab_lo = running && ph == half;
  wire grab_all = running && last_ph;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (accept) next_state = ST_RUN;
      ST_RUN: if (grab_all) next_state = ST_IDLE;
    endcase
  end

  // the sequence counts aclk edges, so a slower clock stretches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      ph <= '0;
      cur <= '0;
      cur_len <= '0;
    end else begin
      state <= next_state;
      if (accept) begin
        cur <= req;
        cur_len <= len_w;
        ph <= '0;
      end else if (running) begin
        ph <= ph + 1'b1;
      end
    end
  end

  wire even_word_wr = req.op == OP_TWRITE && !req.table_pointer[0] && !width_8bit &&
                      mode == WMODE_WORD_WRITE;
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_latch <= 8'h00;
    else if (accept && even_word_wr) hold_latch <= req.table_latch_byte;
  end

  // ------------------------------------------------------------
  // pin values
  // ------------------------------------------------------------
  always_comb begin
    run_pins = '0;
    run_pins.addr_hi = cur.table_pointer[20:17];
    run_pins.oe_n = 1'b1;
    run_pins.write_high_strobe_n = 1'b1;
    run_pins.write_low_strobe_n = 1'b1;
    run_pins.upper_byte_sel_n = 1'b1;
    run_pins.lower_byte_sel_n = 1'b1;
    run_pins.ce_n = 1'b0;
    if (ph == '0) begin
      run_pins.ale = 1'b1;
      run_pins.ad = cur.table_pointer[16:1];
      run_pins.ad_oe = 2'h3;
      run_pins.byte_address_lsb = ptr0 & ~(width_8bit & ~is_wr);
    end else if (!is_wr) begin
      // upper lines stay address-only in 8-bit mode
      run_pins.ad = {cur.table_pointer[16:9], 8'h00};
      run_pins.ad_oe = width_8bit ? 2'h2 : 2'h0;
      run_pins.oe_n = 1'b0;
      run_pins.byte_address_lsb = width_8bit ? second : ptr0;
      run_pins.upper_byte_sel_n = width_8bit;
      run_pins.lower_byte_sel_n = width_8bit;
    end else if (width_8bit) begin
      run_pins.ad = {cur.table_pointer[16:9], d};
      run_pins.ad_oe = 2'h3;
      run_pins.write_low_strobe_n = 1'b0;
      run_pins.byte_address_lsb = ptr0;
    end else begin
      unique case (mode)
        WMODE_BYTE_WRITE: begin
          run_pins.ad = {d, d};
          run_pins.ad_oe = 2'h3;
          run_pins.write_high_strobe_n = ~ptr0;
          run_pins.write_low_strobe_n = ptr0;
        end
        WMODE_WORD_WRITE: begin
          run_pins.byte_address_lsb = ptr0;
          run_pins.upper_byte_sel_n = 1'b0;
          run_pins.lower_byte_sel_n = 1'b0;
          if (ptr0) begin
            run_pins.ad = {d, hold_latch};
            run_pins.ad_oe = 2'h3;
            run_pins.write_high_strobe_n = 1'b0;
          end
        end
        WMODE_BYTE_SELECT: begin
          run_pins.ad = {d, d};
          run_pins.ad_oe = 2'h3;
          run_pins.write_high_strobe_n = 1'b0;
          run_pins.byte_address_lsb = ptr0;
          run_pins.upper_byte_sel_n = ~ptr0;
          run_pins.lower_byte_sel_n = ptr0;
        end
      endcase
    end
  end

  always_comb begin
    next_pins = pins;
    if (low_power) begin
      next_pins.ce_n = 1'b1;
      next_pins.upper_byte_sel_n = 1'b1;
      next_pins.lower_byte_sel_n = 1'b1;
    end else if (state == ST_RUN) begin
      next_pins = run_pins;
    end else begin
      next_pins = '0;
      next_pins.addr_hi = pins.addr_hi;
      next_pins.oe_n = 1'b1;
      next_pins.write_high_strobe_n = 1'b1;
      next_pins.write_low_strobe_n = 1'b1;
      next_pins.ce_n = 1'b1;
      next_pins.upper_byte_sel_n = 1'b1;
      next_pins.lower_byte_sel_n = 1'b1;
    end
  end

  wire next_to_bus = ~ext_bus_control[`EMB_CTRL_DIS_BIT] | (next_state == ST_RUN) |
                     exec_external;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, write_high_strobe_n: 1'b1,
                write_low_strobe_n: 1'b1, upper_byte_sel_n: 1'b1,
                lower_byte_sel_n: 1'b1, default: '0};
      pins_to_bus <= 1'b1;
      req_ready <= 1'b0;
    end else begin
      pins <= next_pins;
      pins_to_bus <= next_to_bus;
      req_ready <= next_state == ST_IDLE && !bus_off;
    end
  end

  // ------------------------------------------------------------
  // read capture
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_s1 <= 16'h0000;
      ad_s2 <= 16'h0000;
      lo_byte <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      ad_s1 <= ad_in;
      ad_s2 <= ad_s1;
      rsp_valid <= grab_all;
      if (grab_lo) lo_byte <= ad_s2[7:0];
      if (grab_all && !is_wr) rsp_data <= width_8bit ? {ad_s2[7:0], lo_byte} : ad_s2;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [LW-1:0] run_cycles;
  logic lp_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn || accept) begin
      run_cycles <= '0;
      lp_seen <= 1'b0;
    end else begin
      if (state == ST_RUN) run_cycles <= run_cycles + 1'b1;
      if (low_power) lp_seen <= 1'b1;
    end
  end

  wire wr16 = !pins.ce_n && !width_8bit && is_wr;
  a_access_len: assert property (@(posedge aclk) disable iff (!aresetn)
    rsp_valid && !lp_seen |-> run_cycles == cur_len)
    else $error("access length differs from configured length");
  a_wait_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    accept |=> cur_len == LW'(TCY_CLKS * (1 + int'($past(wait_n)))))
    else $error("wait states not applied");
  a_byte_wr_lane: assert property (@(posedge aclk) disable iff (!aresetn)
    wr16 && mode == WMODE_BYTE_WRITE && !pins.ale |->
    pins.ad[15:8] == pins.ad[7:0] && pins.write_high_strobe_n != pins.write_low_strobe_n)
    else $error("byte write lanes or strobe wrong");
  a_word_even: assert property (@(posedge aclk) disable iff (!aresetn)
    wr16 && mode == WMODE_WORD_WRITE && !ptr0 && !pins.ale |->
    pins.ad_oe == 2'h0 && pins.write_high_strobe_n && pins.write_low_strobe_n)
    else $error("even word write drove bus or strobe");
  a_word_odd: assert property (@(posedge aclk) disable iff (!aresetn)
    wr16 && mode == WMODE_WORD_WRITE && !pins.write_high_strobe_n |->
    pins.ad[7:0] == hold_latch && pins.ad[15:8] == d)
    else $error("odd word write data wrong");
  a_word_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    wr16 && mode == WMODE_WORD_WRITE && !pins.ale |->
    pins.write_low_strobe_n && !pins.upper_byte_sel_n && !pins.lower_byte_sel_n)
    else $error("word write selects wrong");
  a_bsel_pick: assert property (@(posedge aclk) disable iff (!aresetn)
    wr16 && mode == WMODE_BYTE_SELECT && !pins.write_high_strobe_n |->
    pins.upper_byte_sel_n == ~pins.byte_address_lsb && pins.lower_byte_sel_n == ptr0)
    else $error("byte select does not follow pointer");
  a_lp_force: assert property (@(posedge aclk) disable iff (!aresetn)
    low_power |=> pins.ce_n && pins.upper_byte_sel_n && pins.lower_byte_sel_n)
    else $error("low power did not force selects high");
  a_lp_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    low_power |=> $stable(pins.ad) && $stable(pins.ad_oe) && $stable(pins.ale) &&
    $stable(pins.write_high_strobe_n) && $stable(ph))
    else $error("bus moved during low power");
  a_idle_float: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_IDLE && !low_power |=> pins.ad_oe == 2'h0 && !pins.ale &&
    !pins.byte_address_lsb && pins.oe_n && pins.ce_n)
    else $error("idle bus not parked");
endmodule : emb_bus_ctrl
`default_nettype wire

// [verif/emb_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module emb_mem_model (
  // bus pins
  input wire logic aclk,
  input wire logic width_8bit,
  input wire emb_pkg::emb_pins_s pins,
  output logic [15:0] ad_in,
  // last data phase seen
  output logic [15:0] seen_ad,
  output logic [1:0] seen_oe,
  output logic [4:0] seen_ctl
);
  import emb_pkg::*;
  // ------------------------------------------------------------
  // memory answers from the latched word address
  // ------------------------------------------------------------
  logic [15:0] word_addr = 16'h0;
  logic [15:0] last = 16'h0;
  wire [15:0] rd_word = {word_addr[7:0] ^ 8'h5a, word_addr[7:0]};
  wire [7:0] rd_byte = pins.byte_address_lsb ? rd_word[15:8] : rd_word[7:0];
  // a released bus shows no stale data, so the last value is inverted
  always_comb begin
    if (!pins.ce_n && !pins.oe_n) begin
      ad_in = width_8bit ? {~last[15:8], rd_byte} : rd_word;
    end else begin
      ad_in = ~last;
    end
  end
  always_ff @(posedge aclk) begin
    last <= ad_in;
    if (pins.ale) begin
      word_addr <= pins.ad;
      seen_ctl[4:3] <= 2'h0;
    end else if (!pins.ce_n) begin
      seen_ad <= pins.ad;
      seen_oe <= pins.ad_oe;
      seen_ctl <= {seen_ctl[4] | !pins.write_high_strobe_n,
        seen_ctl[3] | !pins.write_low_strobe_n, pins.upper_byte_sel_n,
        pins.lower_byte_sel_n, pins.byte_address_lsb};
    end
  end
endmodule : emb_mem_model
`default_nettype wire

// [verif/emb_bus_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module emb_bus_ctrl_tb_top;
  import emb_pkg::*;
  localparam int TCY = 8;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, req_ready, rsp_valid, pins_to_bus;
  logic [1:0] bresp, rresp, seen_oe, bres;
  logic [31:0] rdata;
  logic req_valid = 1'h0, sleep_mode = 1'h0, idle_mode = 1'h0, exec_external = 1'h0;
  logic width_8bit = 1'h0, wait_enable = 1'h0;
  emb_req_s req = '0;
  logic [15:0] rsp_data, ad_in, seen_ad;
  logic [4:0] seen_ctl;
  emb_pins_s pins;
  int err_total = 0, check_count = 0, lat, lat0;
  always #20 aclk = ~aclk;

  emb_bus_ctrl #(.TCY_CLKS(TCY)) u_emb_bus_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .exec_external(exec_external), .width_8bit(width_8bit), .wait_enable(wait_enable),
    .ad_in(ad_in), .pins(pins), .pins_to_bus(pins_to_bus), .pull_up_config(),
    .module_power_disable());
  emb_mem_model u_emb_mem_model (.aclk(aclk), .width_8bit(width_8bit), .pins(pins),
    .ad_in(ad_in), .seen_ad(seen_ad), .seen_oe(seen_oe), .seen_ctl(seen_ctl));

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp

  // ------------------------------------------------------------
  // bus masters: handshakes judged at the falling edge before the take
  // ------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      bres = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, hr;
    logic [33:0] got;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    hr = 1'h0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      got = {rresp, rdata};
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    cmp(got, {er, e}, "register read");
  endtask : axr

  task automatic core(input emb_op_e op, input logic [20:0] p, input logic [7:0] b,
                      input logic [1:0] lp);
    logic ht;
    logic [17:0] snap;
    @(posedge aclk);
    req_valid <= 1'h1;
    req <= '{op: op, table_pointer: p, table_latch_byte: b};
    ht = 1'h0;
    while (!ht) begin
      @(negedge aclk);
      ht = req_ready;
      @(posedge aclk);
    end
    req_valid <= 1'h0;
    lat = 0;
    if (lp != 2'h0) begin
      repeat (4) @(posedge aclk);
      {idle_mode, sleep_mode} <= lp;
      repeat (2) @(negedge aclk);
      snap = {pins.ad, pins.ale, pins.oe_n};
      repeat (2) @(negedge aclk);
      cmp({pins.ad, pins.ale, pins.oe_n}, snap, "frozen bus");
      cmp({pins.ce_n, pins.upper_byte_sel_n, pins.lower_byte_sel_n}, 3'h7, "sleep pins");
      @(posedge aclk);
      {idle_mode, sleep_mode} <= 2'h0;
    end
    do begin
      @(negedge aclk);
      lat++;
    end while (rsp_valid !== 1'h1);
    if (op != OP_TWRITE) cmp(rsp_data, {p[8:1] ^ 8'h5a, p[8:1]}, "read data");
  endtask : core

  task automatic tw(input logic [1:0] m, input logic [20:0] p, input logic [7:0] b);
    axw(8'h00, {30'h0, m});
    core(OP_TWRITE, p, b, 1'h0);
  endtask : tw

  initial begin
    #2000000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    axr(8'h00, 32'h30, 2'h0);
    axr(8'h10, 32'h0, 2'h3);
    axw(8'h04, 32'ha5);
    cmp(bres, 2'h0, "write resp");
    axw(8'h10, 32'h1);
    cmp(bres, 2'h3, "unmapped write");
    axr(8'h04, 32'ha5, 2'h0);
    wait_enable <= 1'h1;
    axw(8'h00, 32'h00);
    core(OP_TREAD, 21'h0246, 8'h0, 1'h0);
    lat0 = lat;
    axw(8'h00, 32'h30);
    core(OP_TREAD, 21'h1a4c, 8'h0, 1'h0);
    cmp(lat - lat0, 3 * TCY, "wait states");
    tw(2'h0, 21'h0101, 8'h3c);
    cmp({seen_ad, seen_ctl[4:3]}, {16'h3c3c, 2'h2}, "byte write odd");
    tw(2'h0, 21'h0100, 8'hc3);
    cmp({seen_ad, seen_ctl[4:3]}, {16'hc3c3, 2'h1}, "byte write even");
    tw(2'h1, 21'h0200, 8'h11);
    cmp({seen_oe, seen_ctl[4:3]}, 4'h0, "word even");
    tw(2'h1, 21'h0201, 8'h22);
    cmp({seen_ad, seen_ctl}, {16'h2211, 5'h11}, "word odd");
    tw(2'h2, 21'h0301, 8'h77);
    cmp({seen_ad, seen_ctl}, {16'h7777, 5'h13}, "select odd");
    tw(2'h2, 21'h0300, 8'h78);
    cmp({seen_ad, seen_ctl}, {16'h7878, 5'h14}, "select even");
    @(posedge aclk);
    width_8bit <= 1'h1;
    core(OP_FETCH, 21'h0c0a, 8'h0, 1'h0);
    core(OP_TWRITE, 21'h0c0b, 8'h5e, 1'h0);
    cmp({seen_ad[7:0], seen_ctl[4:3], seen_ctl[0]}, {8'h5e, 3'h3}, "narrow write");
    @(posedge aclk);
    width_8bit <= 1'h0;
    core(OP_TREAD, 21'h0e0e, 8'h0, 2'h1);
    core(OP_TREAD, 21'h0e10, 8'h0, 2'h2);
    // one cycle after rsp_valid the pins are parked: bus released, strobes and selects high
    @(negedge aclk);
    cmp({pins.ad_oe, pins.ale, pins.oe_n, pins.write_high_strobe_n, pins.write_low_strobe_n,
      pins.ce_n, pins.upper_byte_sel_n, pins.lower_byte_sel_n, pins.byte_address_lsb},
      11'h07e, "parked pins");
    axw(8'h00, 32'h80);
    repeat (2) @(negedge aclk);
    cmp(pins_to_bus, 1'h0, "pins released");
    @(posedge aclk);
    exec_external <= 1'h1;
    repeat (2) @(negedge aclk);
    cmp(pins_to_bus, 1'h1, "pins reclaimed");
    axr(8'h0c, 32'h4, 2'h0);
    axw(8'h08, 32'h3);
    axr(8'h08, 32'h1, 2'h0);
    @(negedge aclk);
    cmp(req_ready, 1'h0, "module off");
    report_and_stop();
  end
endmodule : emb_bus_ctrl_tb_top
`default_nettype wire
